// file: core/parallel_io_consts.vh
// Constants for the two-port parallel I/O block: offsets, reset values and masks.
`ifndef PARALLEL_IO_CONSTS_VH
`define PARALLEL_IO_CONSTS_VH
`define PORT_W             16
`define OFS_A_DIR          12'h000
`define OFS_A_LATCH        12'h004
`define OFS_A_LEVEL        12'h008
`define OFS_A_ODSEL        12'h00C
`define OFS_A_ANSEL        12'h010
`define OFS_B_DIR          12'h020
`define OFS_B_LATCH        12'h024
`define OFS_B_LEVEL        12'h028
`define OFS_B_ODSEL        12'h02C
`define OFS_B_ANSEL        12'h030
`define DIR_RESET          16'hFFFF
`define LATCH_RESET        16'h0000
`define ODSEL_RESET        16'h0000
`define ANSEL_A_MASK       16'h000F
`define ANSEL_B_MASK       16'hF01F
`define ANSEL_B_MASK_MID   16'hF017
`define ANSEL_B_MASK_SMALL 16'hC010
`define PKG_LARGE          2'h0
`define PKG_MID            2'h1
`define PKG_SMALL          2'h2
`endif

// file: core/parallel_io_port.v
// Two 16-bit parallel I/O ports with peripheral override, open drain and analog select, on APB.
`timescale 1ns/1ps
`include "parallel_io_consts.vh"
module parallel_io_port #(
  parameter [15:0] PORT_A_VALID = 16'hFFFF,
  parameter [15:0] PORT_B_VALID = 16'hFFFF,
  parameter [1:0]  PACKAGE_SEL  = 2'h0
) (
  // APB clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Port A pins
  input  wire [15:0] pa_in,
  output reg  [15:0] pa_out,
  output reg  [15:0] pa_oe,
  // Port B pins
  input  wire [15:0] pb_in,
  output reg  [15:0] pb_out,
  output reg  [15:0] pb_oe,
  // Peripheral drive requests, data and input-only view of the pins
  input  wire [15:0] pa_periph_drive,
  input  wire [15:0] pa_periph_data,
  input  wire [15:0] pb_periph_drive,
  input  wire [15:0] pb_periph_data,
  output reg  [15:0] pa_digital_in,
  output reg  [15:0] pb_digital_in
);

  // Package-dependent port B analog bit set.
  localparam [15:0] ANSEL_B_IMPL = (PACKAGE_SEL == `PKG_SMALL) ? `ANSEL_B_MASK_SMALL :
                                   (PACKAGE_SEL == `PKG_MID)   ? `ANSEL_B_MASK_MID   : `ANSEL_B_MASK;
  localparam [15:0] ANSEL_A_IMPL = `ANSEL_A_MASK & PORT_A_VALID;
  localparam [15:0] ANSEL_B_USE  = ANSEL_B_IMPL & PORT_B_VALID;

  // One-hot register selects; all zero marks an unmapped address.
  localparam [9:0]  SEL_NONE     = 10'h000;
  localparam [9:0]  SEL_A_DIR    = 10'h001;
  localparam [9:0]  SEL_A_LATCH  = 10'h002;
  localparam [9:0]  SEL_A_LEVEL  = 10'h004;
  localparam [9:0]  SEL_A_ODSEL  = 10'h008;
  localparam [9:0]  SEL_A_ANSEL  = 10'h010;
  localparam [9:0]  SEL_B_DIR    = 10'h020;
  localparam [9:0]  SEL_B_LATCH  = 10'h040;
  localparam [9:0]  SEL_B_LEVEL  = 10'h080;
  localparam [9:0]  SEL_B_ODSEL  = 10'h100;
  localparam [9:0]  SEL_B_ANSEL  = 10'h200;

  reg  [15:0] a_dir_reg;
  reg  [15:0] a_latch_reg;
  reg  [15:0] a_odsel_reg;
  reg  [15:0] a_ansel_reg;
  reg  [15:0] b_dir_reg;
  reg  [15:0] b_latch_reg;
  reg  [15:0] b_odsel_reg;
  reg  [15:0] b_ansel_reg;
  reg  [15:0] pa_sync1_reg;
  reg  [15:0] pa_sync2_reg;
  reg  [15:0] pb_sync1_reg;
  reg  [15:0] pb_sync2_reg;
  reg  [31:0] rdata_next;
  reg         err_next;
  reg  [15:0] pa_out_next;
  reg  [15:0] pa_oe_next;
  reg  [15:0] pb_out_next;
  reg  [15:0] pb_oe_next;
  wire [9:0]  sel;
  wire        setup;
  wire        wr;
  wire [15:0] wd;
  wire [15:0] a_level;
  wire [15:0] b_level;

  // Output and enable multiplexer for one pin group.
  function [31:0] pin_drive;
    input [15:0] drive;
    input [15:0] pdata;
    input [15:0] latch;
    input [15:0] dir;
    input [15:0] odsel;
    input [15:0] valid;
    reg   [15:0] dat;
    reg   [15:0] en;
    begin
      dat = (drive & pdata) | (~drive & latch);
      en  = drive | ~dir;
      // Open drain drives only zero from the latch, and a high is left to the pull-up; a peripheral-driven pin drives both levels.
      en  = en & ~(~drive & odsel & latch);
      pin_drive = {dat & valid, en & valid};
    end
  endfunction

  // Decoding once keeps the write strobes and the read mux from drifting apart.
  function [9:0] reg_select;
    input [11:0] addr;
    begin
      case (addr)
        `OFS_A_DIR:   reg_select = SEL_A_DIR;
        `OFS_A_LATCH: reg_select = SEL_A_LATCH;
        `OFS_A_LEVEL: reg_select = SEL_A_LEVEL;
        `OFS_A_ODSEL: reg_select = SEL_A_ODSEL;
        `OFS_A_ANSEL: reg_select = SEL_A_ANSEL;
        `OFS_B_DIR:   reg_select = SEL_B_DIR;
        `OFS_B_LATCH: reg_select = SEL_B_LATCH;
        `OFS_B_LEVEL: reg_select = SEL_B_LEVEL;
        `OFS_B_ODSEL: reg_select = SEL_B_ODSEL;
        `OFS_B_ANSEL: reg_select = SEL_B_ANSEL;
        default:      reg_select = SEL_NONE;
      endcase
    end
  endfunction

  // Pins come from outside the clock domain and pass two flops first.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_sync1_reg <= 16'h0000;
      pa_sync2_reg <= 16'h0000;
    end else begin
      pa_sync1_reg <= pa_in;
      pa_sync2_reg <= pa_sync1_reg;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_sync1_reg <= 16'h0000;
      pb_sync2_reg <= 16'h0000;
    end else begin
      pb_sync1_reg <= pb_in;
      pb_sync2_reg <= pb_sync1_reg;
    end
  end

  // Analog-selected pins have their input buffer off and read low.
  assign a_level = pa_sync2_reg & ~a_ansel_reg & PORT_A_VALID;
  assign b_level = pb_sync2_reg & ~b_ansel_reg & PORT_B_VALID;

  assign setup = psel & ~penable;
  assign wr    = psel & penable & pwrite & pready;
  assign wd    = pwdata[15:0];
  assign sel   = reg_select(paddr);

  // Register writes land at the access edge, when pready is already high.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_dir_reg <= `DIR_RESET & PORT_A_VALID;
    end else if (wr && (sel == SEL_A_DIR)) begin
      a_dir_reg <= wd & PORT_A_VALID;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_latch_reg <= `LATCH_RESET;
    end else if (wr && (sel == SEL_A_LATCH)) begin
      a_latch_reg <= wd & PORT_A_VALID;
    end else if (wr && (sel == SEL_A_LEVEL)) begin
      a_latch_reg <= wd & PORT_A_VALID;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_odsel_reg <= `ODSEL_RESET;
    end else if (wr && (sel == SEL_A_ODSEL)) begin
      a_odsel_reg <= wd & PORT_A_VALID;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_ansel_reg <= ANSEL_A_IMPL;
    end else if (wr && (sel == SEL_A_ANSEL)) begin
      a_ansel_reg <= wd & ANSEL_A_IMPL;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_dir_reg <= `DIR_RESET & PORT_B_VALID;
    end else if (wr && (sel == SEL_B_DIR)) begin
      b_dir_reg <= wd & PORT_B_VALID;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_latch_reg <= `LATCH_RESET;
    end else if (wr && (sel == SEL_B_LATCH)) begin
      b_latch_reg <= wd & PORT_B_VALID;
    end else if (wr && (sel == SEL_B_LEVEL)) begin
      b_latch_reg <= wd & PORT_B_VALID;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_odsel_reg <= `ODSEL_RESET;
    end else if (wr && (sel == SEL_B_ODSEL)) begin
      b_odsel_reg <= wd & PORT_B_VALID;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_ansel_reg <= ANSEL_B_USE;
    end else if (wr && (sel == SEL_B_ANSEL)) begin
      b_ansel_reg <= wd & ANSEL_B_USE;
    end
  end

  // Read mux, evaluated in the setup cycle; unmapped addresses answer with an error.
  always @* begin
    rdata_next = 32'h00000000;
    err_next   = 1'b0;
    case (sel)
      SEL_A_DIR:   rdata_next = {16'h0000, a_dir_reg};
      SEL_A_LATCH: rdata_next = {16'h0000, a_latch_reg};
      SEL_A_LEVEL: rdata_next = {16'h0000, a_level};
      SEL_A_ODSEL: rdata_next = {16'h0000, a_odsel_reg};
      SEL_A_ANSEL: rdata_next = {16'h0000, a_ansel_reg};
      SEL_B_DIR:   rdata_next = {16'h0000, b_dir_reg};
      SEL_B_LATCH: rdata_next = {16'h0000, b_latch_reg};
      SEL_B_LEVEL: rdata_next = {16'h0000, b_level};
      SEL_B_ODSEL: rdata_next = {16'h0000, b_odsel_reg};
      SEL_B_ANSEL: rdata_next = {16'h0000, b_ansel_reg};
      default:      err_next   = 1'b1;
    endcase
  end

  // No wait state: data is captured in setup and presented in the access phase.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata  <= pwrite ? 32'h00000000 : rdata_next;
        pslverr <= err_next;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always @* begin
    {pa_out_next, pa_oe_next} = pin_drive(pa_periph_drive, pa_periph_data, a_latch_reg,
                                          a_dir_reg, a_odsel_reg, PORT_A_VALID);
  end

  always @* begin
    {pb_out_next, pb_oe_next} = pin_drive(pb_periph_drive, pb_periph_data, b_latch_reg,
                                          b_dir_reg, b_odsel_reg, PORT_B_VALID);
  end

  // Registered pin drive; a write shows on the pins one cycle later, so software must wait.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_out        <= 16'h0000;
      pa_oe         <= 16'h0000;
      pa_digital_in <= 16'h0000;
    end else begin
      pa_out        <= pa_out_next;
      pa_oe         <= pa_oe_next;
      pa_digital_in <= a_level;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_out        <= 16'h0000;
      pb_oe         <= 16'h0000;
      pb_digital_in <= 16'h0000;
    end else begin
      pb_out        <= pb_out_next;
      pb_oe         <= pb_oe_next;
      pb_digital_in <= b_level;
    end
  end

endmodule

// file: tb/pin_model.sv
// Board model for one port: the port level where enabled, the outside level elsewhere.
`timescale 1ns/1ps
module pin_model (
  input  logic [15:0] out,
  input  logic [15:0] oe,
  input  logic [15:0] ext,
  output logic [15:0] pin
);
  assign pin = (out & oe) | (ext & ~oe);
endmodule

// file: tb/parallel_io_port_monitor.sv
// Checker on the ports of the parallel I/O block.
`timescale 1ns/1ps
module parallel_io_port_monitor (
  // Bus
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // Pin enables and peripheral drive requests
  input logic [15:0] pa_oe,
  input logic [15:0] pb_oe,
  input logic [15:0] pa_periph_drive,
  input logic [15:0] pb_periph_drive
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_SETUP_READY: assert property (psel && !penable |=> pready) else $error("no ready");
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("long ready");
  AST_IDLE_QUIET: assert property (!psel |-> !pready) else $error("idle ready");
  AST_ERR_READY: assert property (pslverr |-> pready) else $error("lone error");
  AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000) else $error("high half");
  AST_RESET_OE: assert property ($rose(presetn) |-> (pa_oe | pb_oe) == 16'h0000) else $error("reset drive");
  AST_PA_DRIVE: assert property ($past(presetn) |-> (pa_oe & $past(pa_periph_drive)) == $past(pa_periph_drive)) else $error("a oe");
  AST_PB_DRIVE: assert property ($past(presetn) |-> (pb_oe & $past(pb_periph_drive)) == $past(pb_periph_drive)) else $error("b oe");
  cover property (pslverr);
  cover property (pready && pwrite);
  cover property (|pa_periph_drive);
endmodule
bind parallel_io_port parallel_io_port_monitor i_parallel_io_port_monitor (.*);

// file: tb/parallel_io_port_bench.sv
// Self-checking bench for the parallel I/O block.
`timescale 1ns/1ps
`include "parallel_io_consts.vh"
module parallel_io_port_bench;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err_v;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, prdata_s;
  logic [15:0] pa_periph_drive = 16'h0000, pa_periph_data = 16'h0000, pb_periph_drive = 16'h0000;
  logic [15:0] pb_periph_data = 16'h0000, ext_a = 16'hC3C3, ext_b = 16'h1234;
  logic [15:0] rd_v, rd_s, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, pa_digital_in, pb_digital_in;
  int          err_count = 0, n_checks = 0;
  parallel_io_port i_parallel_io_port (.*);
  // Smallest package with one missing port B bit; it sees the same bus and answers in step.
  parallel_io_port #(
    .PORT_A_VALID (16'hFFFF),
    .PORT_B_VALID (16'hFFFB),
    .PACKAGE_SEL  (`PKG_SMALL)
  ) i_parallel_io_port_small (
    .pclk            (pclk),
    .presetn         (presetn),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata_s),
    .pready          (),
    .pslverr         (),
    .pa_in           (ext_a),
    .pa_out          (),
    .pa_oe           (),
    .pb_in           (ext_b),
    .pb_out          (),
    .pb_oe           (),
    .pa_periph_drive (pa_periph_drive),
    .pa_periph_data  (pa_periph_data),
    .pb_periph_drive (pb_periph_drive),
    .pb_periph_data  (pb_periph_data),
    .pa_digital_in   (),
    .pb_digital_in   ()
  );
  pin_model i_pin_model_a (.out(pa_out), .oe(pa_oe), .ext(ext_a), .pin(pa_in));
  pin_model i_pin_model_b (.out(pb_out), .oe(pb_oe), .ext(ext_b), .pin(pb_in));
  initial forever #50 pclk = ~pclk;
  task automatic finish_test(input int late);
    err_count += late;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, e);
    n_checks++;
    if (s !== e)
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    err_count += int'(s !== e);
  endtask
  // The request holds until pready is seen, for up to 20 cycles, so no fixed slave latency is assumed.
  task automatic apb(input logic [11:0] a, input logic w, input logic [15:0] d);
    int i = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++i < 20);
    if (pready !== 1'b1)
      finish_test(1);
    {err_v, rd_v, rd_s} = {pslverr, prdata[15:0], prdata_s[15:0]};
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [15:0] e);
    apb(a, 1'b0, 16'h0000);
    chk(n, rd_v, e);
  endtask
  task automatic pins(input logic [15:0] oe, out);
    repeat (2) @(posedge pclk);
    chk("pa_oe", pa_oe, oe);
    chk("pa_out", pa_out, out);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd("a_dir", `OFS_A_DIR, 16'hFFFF);
    rd("b_dir", `OFS_B_DIR, 16'hFFFF);
    chk("b_dir_small", rd_s, 16'hFFFB);
    rd("b_ansel", `OFS_B_ANSEL, 16'hF01F);
    chk("b_ansel_small", rd_s, 16'hC010);
    rd("b_level", `OFS_B_LEVEL, 16'h0220);
    chk("b_level_small", rd_s, 16'h1220);
    chk("b_dig", pb_digital_in, 16'h0220);
    rd("a_ansel", `OFS_A_ANSEL, 16'h000F);
    rd("a_level", `OFS_A_LEVEL, 16'hC3C0);
    chk("a_dig", pa_digital_in, 16'hC3C0);
    apb(`OFS_A_ANSEL, 1'b1, 16'hFFFF);
    rd("a_ansel", `OFS_A_ANSEL, 16'h000F);
    apb(`OFS_B_ANSEL, 1'b1, 16'hFFFF);
    rd("b_ansel", `OFS_B_ANSEL, 16'hF01F);
    apb(`OFS_B_ANSEL, 1'b1, 16'h0000);
    apb(`OFS_A_DIR, 1'b1, 16'h000F);
    apb(`OFS_A_LATCH, 1'b1, 16'hA5A5);
    pins(16'hFFF0, 16'hA5A5);
    rd("b_level", `OFS_B_LEVEL, 16'h1234);
    rd("a_level", `OFS_A_LEVEL, 16'hA5A0);
    apb(`OFS_A_LEVEL, 1'b1, 16'h5A5A);
    rd("a_latch", `OFS_A_LATCH, 16'h5A5A);
    apb(`OFS_A_ODSEL, 1'b1, 16'h00FF);
    pins(16'hFFA0, 16'h5A5A);
    {pa_periph_drive, pa_periph_data, pb_periph_drive, pb_periph_data} <= {16'h000F, 16'h0009, 16'h0001, 16'h0001};
    pins(16'hFFAF, 16'h5A59);
    chk("b_oe", pb_oe, 16'h0001);
    chk("b_out", pb_out, 16'h0001);
    repeat (2) @(posedge pclk);
    rd("a_level", `OFS_A_LEVEL, 16'h5A40);
    rd("a_latch", `OFS_A_LATCH, 16'h5A5A);
    pa_periph_drive <= 16'h0000;
    pins(16'hFFA0, 16'h5A5A);
    rd("unmapped", 12'h040, 16'h0000);
    chk("slverr", {15'h0000, err_v}, 16'h0001);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd("a_dir_rst", `OFS_A_DIR, 16'hFFFF);
    rd("a_latch_rst", `OFS_A_LATCH, 16'h0000);
    finish_test(0);
  end
endmodule
